// file: design/tfc_ctrl_bank.v
/*
 Control register bank for a T1 framer: two receive framer registers and
 one transmit formatter register, plus the per-frame control decode.
 Assumes a synchronous 8-bit parallel port on mclk_i, frame boundary
 strobes from the framer and formatter, and pin inputs from other domains.
 Unmapped offsets read as zero and ignore writes.
*/
// Behaviour
// RL1: Violation counter adds excessive-zeros events when function bit set.
// RL2: Resync on out-of-frame or carrier loss, or out-of-frame only.
// RL3: Out-of-frame at 2 errors within 4, 5 or 6 framing bits.
// RL4: Sync criteria selects sequential/cross-coupled D4, or CRC6-verified ESF search.
// RL5: Sync qualify 10 framing bits when 0, 24 when 1.
// RL6: Auto resync only while disable bit is 0.
// RL7: Rising edge of resync bit starts one resync; software re-arms.
// RL8: Substitution code is 7F idle or the eight-byte milliwatt sequence.
// RL9: Receive zero byte interchange enabled by its bit.
// RL10: Double-wide sync pulses in signaling frames; masked in multiframe mode or with pin input.
// RL11: Sync mode picks frame or multiframe pulses; ignored when pin input.
// RL12: Sync pin output at 0, input at 1 only with elastic store.
// RL13: Receive D4 yellow: bit-2 zeros or frame-12 S-bit.
// RL14: Path counter counts Ft errors, or Fs and Ft errors.
// RL15: Multiframe counter counts framing errors or multiframes out of sync.
// RL16: Fall back to recovered clock when transmit clock stops, if enabled.
// RL17: F bits and CRC6 passed through from serial input when enabled.
// RL18: Register signaling inserted unless blocked per channel, when enabled.
// RL19: Global bit 7 stuffing, else transparency bits decide.
// RL20: Data link source is legacy register or HDLC/link pin.
// RL21: Blue alarm sends unframed all ones.
// RL22: Yellow alarm transmitted when its bit is set.
// RL23: Transmitted D4 yellow format follows transmit select bit.
// RL24: Elastic store enable gates sync pin input mode.
// RL25: Control bits take effect at next frame boundary of their side; the resync bit and the clock fallback bit act at once.
`timescale 1ns/1ps
`include "tfc_defs.vh"

module tfc_ctrl_bank (
	input wire mclk_i,
	input wire rst_i,
	input wire cs_n_i,
	input wire wr_n_i,
	input wire rd_n_i,
	input wire [7:0] addr_i,
	input wire [7:0] wdata_i,
	output reg [7:0] rdata_o,
	input wire rx_frame_i,
	input wire tx_frame_i,
	input wire receive_elastic_store_en_i,
	input wire tx_d4_yellow_select_i,
	input wire out_of_frame_i,
	input wire receive_carrier_loss_i,
	input wire rx_fbit_valid_i,
	input wire rx_fbit_err_i,
	input wire rx_fbit_is_fs_i,
	input wire rx_excess_zeros_i,
	input wire rx_mf_out_of_sync_i,
	input wire [2:0] rx_mf_index_i,
	input wire transmit_line_clock_i,
	input wire tx_word_valid_i,
	output wire tx_word_ready_o,
	input wire [7:0] tx_word_i,
	output wire rx_resync_o,
	output reg rx_oof_o,
	output reg [4:0] rx_qualify_count_o,
	output reg rx_sync_cross_couple_o,
	output reg rx_sync_crc_verify_o,
	input wire rx_esf_mode_i,
	output reg [7:0] rx_sub_code_o,
	output reg receive_zero_byte_interchange_en_o,
	output reg receive_sync_double_wide_o,
	output reg receive_sync_multiframe_mode_o,
	output reg receive_sync_pin_oe_n_o,
	output reg receive_d4_yellow_select_o,
	output reg violation_count_excess_zero_o,
	output reg path_count_inc_o,
	output reg mf_count_inc_o,
	output reg tx_use_recovered_clock_o,
	output reg framing_bit_pass_through_o,
	output reg crc_pass_through_o,
	output reg software_signaling_insert_en_o,
	output reg global_bit7_stuffing_o,
	output reg data_link_source_select_o,
	output reg transmit_blue_alarm_o,
	output reg transmit_yellow_alarm_o,
	output reg transmit_d4_yellow_select_o,
	output wire tx_out_valid_o,
	input wire tx_out_ready_i,
	output wire [7:0] tx_out_word_o
);

	reg [7:0] rx_ctrl_a;
	reg [7:0] rx_ctrl_b;
	reg [7:0] tx_ctrl_a;
	reg [7:0] rx_act_a;
	reg [7:0] rx_act_b;
	reg resync_prev;
	reg resync_req;
	reg auto_resync;
	reg [5:0] fbit_hist;
	reg [2:0] oof_win;
	reg [2:0] err_cnt;
	reg [2:0] mw_idx;
	reg [7:0] mw_code;
	reg transmit_line_clock_s1;
	reg transmit_line_clock_s2;
	reg transmit_line_clock_s3;
	reg transmit_line_clock_level;
	reg [7:0] loss_cnt;
	reg [7:0] buf_data0;
	reg [7:0] buf_data1;
	reg buf_full0;
	reg buf_full1;
	reg [7:0] next_word;
	integer i;
	wire wr_en;
	wire rd_en;
	wire oof_trigger;
	wire sync_pin_input;

	assign wr_en = !cs_n_i && !wr_n_i;
	assign rd_en = !cs_n_i && !rd_n_i;
	// Out-of-frame and sync pin qualifiers
	assign oof_trigger = (err_cnt >= `TFC_OOF_ERRS);
	assign sync_pin_input = rx_act_b[`TFC_RB_DIR] && receive_elastic_store_en_i; // RL12 RL24

	// Register writes and reads
	always @(posedge mclk_i) begin
		if (rst_i) begin
			rx_ctrl_a <= `TFC_RESET_VAL;
			rx_ctrl_b <= `TFC_RESET_VAL;
			tx_ctrl_a <= `TFC_RESET_VAL;
			rdata_o <= 8'h00;
		end else begin
			if (wr_en) begin
				case (addr_i)
					`TFC_ADDR_RX_A: rx_ctrl_a <= wdata_i;
					`TFC_ADDR_RX_B: rx_ctrl_b <= wdata_i;
					`TFC_ADDR_TX_A: tx_ctrl_a <= wdata_i;
					default: ;
				endcase
			end
			// Unmapped offsets read as zero
			if (rd_en) begin
				case (addr_i)
					`TFC_ADDR_RX_A: rdata_o <= rx_ctrl_a;
					`TFC_ADDR_RX_B: rdata_o <= rx_ctrl_b;
					`TFC_ADDR_TX_A: rdata_o <= tx_ctrl_a;
					default: rdata_o <= 8'h00;
				endcase
			end
		end
	end

	// Resync edge detect acts at once; configuration waits for frame boundary
	always @(posedge mclk_i) begin
		if (rst_i) begin
			rx_act_a <= `TFC_RESET_VAL;
			rx_act_b <= `TFC_RESET_VAL;
			resync_prev <= 1'b0;
			resync_req <= 1'b0;
		end else begin
			resync_prev <= rx_ctrl_a[`TFC_RA_RESYNC];
			if (rx_ctrl_a[`TFC_RA_RESYNC] && !resync_prev) begin
				resync_req <= 1'b1; // RL7
			end else begin
				resync_req <= 1'b0;
			end
			if (rx_frame_i) begin
				rx_act_a <= rx_ctrl_a; // RL25
				rx_act_b <= rx_ctrl_b; // RL25
			end
		end
	end

	// Resync trigger criteria
	always @* begin
		if (rx_act_a[`TFC_RA_ARC]) begin
			auto_resync = out_of_frame_i; // RL2
		end else begin
			auto_resync = out_of_frame_i || receive_carrier_loss_i; // RL2
		end
	end
	assign rx_resync_o = resync_req || (auto_resync && !rx_act_a[`TFC_RA_ARDIS]); // RL6

	// Out-of-frame window selection
	always @* begin
		if (rx_act_a[`TFC_RA_OOFB]) begin
			oof_win = `TFC_OOF_WIN_6; // RL3
		end else if (rx_act_a[`TFC_RA_OOFA]) begin
			oof_win = `TFC_OOF_WIN_5; // RL3
		end else begin
			oof_win = `TFC_OOF_WIN_4; // RL3
		end
		err_cnt = 3'd0;
		for (i = 0; i < 6; i = i + 1) begin
			if (i < oof_win && fbit_hist[i]) begin
				err_cnt = err_cnt + 3'd1;
			end
		end
	end

	// Framing bit history, counter strobes
	always @(posedge mclk_i) begin
		if (rst_i) begin
			fbit_hist <= 6'h00;
			rx_oof_o <= 1'b0;
			path_count_inc_o <= 1'b0;
			mf_count_inc_o <= 1'b0;
			violation_count_excess_zero_o <= 1'b0;
		end else begin
			violation_count_excess_zero_o <= rx_excess_zeros_i && rx_act_a[`TFC_RA_VCF]; // RL1
			path_count_inc_o <= rx_fbit_valid_i && rx_fbit_err_i
				&& (!rx_fbit_is_fs_i || rx_act_b[`TFC_RB_FSE]); // RL14
			if (rx_act_b[`TFC_RB_MOSC]) begin
				mf_count_inc_o <= rx_frame_i && rx_mf_out_of_sync_i; // RL15
			end else begin
				mf_count_inc_o <= rx_fbit_valid_i && rx_fbit_err_i; // RL15
			end
			// Resync restarts the history, so it outranks a pending set
			if (rx_resync_o) begin
				fbit_hist <= 6'h00;
				rx_oof_o <= 1'b0;
			end else if (rx_fbit_valid_i) begin
				fbit_hist <= {fbit_hist[4:0], rx_fbit_err_i};
			end else if (oof_trigger) begin
				rx_oof_o <= 1'b1; // RL3
			end
		end
	end

	// Sync search setup and receive pin options
	always @(posedge mclk_i) begin
		if (rst_i) begin
			rx_qualify_count_o <= `TFC_QUAL_SHORT;
			rx_sync_cross_couple_o <= 1'b0;
			rx_sync_crc_verify_o <= 1'b0;
			receive_zero_byte_interchange_en_o <= 1'b0;
			receive_sync_double_wide_o <= 1'b0;
			receive_sync_multiframe_mode_o <= 1'b0;
			receive_sync_pin_oe_n_o <= 1'b0;
			receive_d4_yellow_select_o <= 1'b0;
		end else begin
			rx_qualify_count_o <= rx_act_a[`TFC_RA_SYNC_QUALIFY_TIME] ? `TFC_QUAL_LONG
				: `TFC_QUAL_SHORT; // RL5
			rx_sync_cross_couple_o <= !rx_esf_mode_i && rx_act_a[`TFC_RA_SYNC_CRITERIA]; // RL4
			rx_sync_crc_verify_o <= rx_esf_mode_i && rx_act_a[`TFC_RA_SYNC_CRITERIA]; // RL4
			receive_zero_byte_interchange_en_o <= rx_act_b[`TFC_RB_ZBTSI]; // RL9
			receive_d4_yellow_select_o <= rx_act_b[`TFC_RB_D4Y]; // RL13
			// Pin input only when elastic store is on
			receive_sync_pin_oe_n_o <= sync_pin_input; // RL12 RL24
			receive_sync_multiframe_mode_o <= rx_act_b[`TFC_RB_MF]
				&& !sync_pin_input; // RL11
			receive_sync_double_wide_o <= rx_act_b[`TFC_RB_DW]
				&& !rx_act_b[`TFC_RB_MF] && !sync_pin_input; // RL10
		end
	end

	// Substitution code
	always @* begin
		case (mw_idx)
			3'd0: mw_code = 8'h1E;
			3'd1: mw_code = 8'h0B;
			3'd2: mw_code = 8'h0B;
			3'd3: mw_code = 8'h1E;
			3'd4: mw_code = 8'h9E;
			3'd5: mw_code = 8'h8B;
			3'd6: mw_code = 8'h8B;
			default: mw_code = 8'h9E;
		endcase
	end
	always @(posedge mclk_i) begin
		if (rst_i) begin
			mw_idx <= 3'd0;
			rx_sub_code_o <= `TFC_IDLE_CODE;
		end else begin
			// Index registered so the code lines up with the frame count
			mw_idx <= rx_mf_index_i;
			rx_sub_code_o <= rx_act_b[`TFC_RB_RCS] ? mw_code : `TFC_IDLE_CODE; // RL8
		end
	end

	// Transmit clock watchdog, three-stage sampled
	always @(posedge mclk_i) begin
		if (rst_i) begin
			transmit_line_clock_s1 <= 1'b0;
			transmit_line_clock_s2 <= 1'b0;
			transmit_line_clock_s3 <= 1'b0;
			transmit_line_clock_level <= 1'b0;
			loss_cnt <= 8'h00;
			tx_use_recovered_clock_o <= 1'b0;
		end else begin
			transmit_line_clock_s1 <= transmit_line_clock_i;
			transmit_line_clock_s2 <= transmit_line_clock_s1;
			transmit_line_clock_s3 <= transmit_line_clock_s2;
			// Edge counts once the second and third stage agree on a new level
			if (transmit_line_clock_s2 == transmit_line_clock_s3 && transmit_line_clock_s3 != transmit_line_clock_level) begin
				transmit_line_clock_level <= transmit_line_clock_s3;
				loss_cnt <= 8'h00;
				tx_use_recovered_clock_o <= 1'b0;
			end else if (loss_cnt >= `TFC_TRANSMIT_LINE_CLOCK_LOSS_CYC) begin
				tx_use_recovered_clock_o <= tx_ctrl_a[`TFC_TA_CLKF]; // RL16
			end else begin
				loss_cnt <= loss_cnt + 8'h01;
			end
		end
	end

	// Transmit formatter controls at transmit frame boundary
	always @(posedge mclk_i) begin
		if (rst_i) begin
			framing_bit_pass_through_o <= 1'b0;
			crc_pass_through_o <= 1'b0;
			software_signaling_insert_en_o <= 1'b0;
			global_bit7_stuffing_o <= 1'b0;
			data_link_source_select_o <= 1'b0;
			transmit_blue_alarm_o <= 1'b0;
			transmit_yellow_alarm_o <= 1'b0;
			transmit_d4_yellow_select_o <= 1'b0;
		end else if (tx_frame_i) begin
			framing_bit_pass_through_o <= tx_ctrl_a[`TFC_TA_FPT]; // RL17
			crc_pass_through_o <= tx_ctrl_a[`TFC_TA_CPT]; // RL17
			software_signaling_insert_en_o <= tx_ctrl_a[`TFC_TA_SSE]; // RL18
			global_bit7_stuffing_o <= tx_ctrl_a[`TFC_TA_GB7]; // RL19
			data_link_source_select_o <= tx_ctrl_a[`TFC_TA_DLS]; // RL20
			transmit_blue_alarm_o <= tx_ctrl_a[`TFC_TA_BLUE]; // RL21
			transmit_yellow_alarm_o <= tx_ctrl_a[`TFC_TA_YEL]; // RL22
			transmit_d4_yellow_select_o <= tx_d4_yellow_select_i; // RL23
		end
	end

	// Two-entry transmit buffer; blue alarm replaces words with all ones
	assign tx_word_ready_o = !buf_full1;
	assign tx_out_valid_o = buf_full0;
	assign tx_out_word_o = buf_data0;
	always @* begin
		next_word = transmit_blue_alarm_o ? 8'hFF : tx_word_i; // RL21
	end
	always @(posedge mclk_i) begin
		if (rst_i) begin
			buf_full0 <= 1'b0;
			buf_full1 <= 1'b0;
			buf_data0 <= 8'h00;
			buf_data1 <= 8'h00;
		end else begin
			case ({tx_word_valid_i && !buf_full1, tx_out_ready_i && buf_full0})
				2'b10: begin
					if (!buf_full0) begin
						buf_data0 <= next_word;
						buf_full0 <= 1'b1;
					end else begin
						buf_data1 <= next_word;
						buf_full1 <= 1'b1;
					end
				end
				2'b01: begin
					buf_data0 <= buf_data1;
					buf_full0 <= buf_full1;
					buf_full1 <= 1'b0;
				end
				2'b11: begin
					if (buf_full1) begin
						buf_data0 <= buf_data1;
						buf_data1 <= next_word;
					end else begin
						buf_data0 <= next_word;
					end
				end
				default: ;
			endcase
		end
	end

endmodule // tfc_ctrl_bank

// file: design/tfc_defs.vh
/*
 Constants for the T1 framer control register bank.
 Assumes inclusion by the bank module only.
*/
`ifndef TFC_DEFS_VH
`define TFC_DEFS_VH
`define TFC_ADDR_RX_A 8'h2B
`define TFC_ADDR_RX_B 8'h2C
`define TFC_ADDR_TX_A 8'h35
`define TFC_RESET_VAL 8'h00
`define TFC_IDLE_CODE 8'h7F
// Receive control A fields
`define TFC_RA_VCF 7
`define TFC_RA_ARC 6
`define TFC_RA_OOFA 5
`define TFC_RA_OOFB 4
`define TFC_RA_SYNC_CRITERIA 3
`define TFC_RA_SYNC_QUALIFY_TIME 2
`define TFC_RA_ARDIS 1
`define TFC_RA_RESYNC 0
// Receive control B fields
`define TFC_RB_RCS 7
`define TFC_RB_ZBTSI 6
`define TFC_RB_DW 5
`define TFC_RB_MF 4
`define TFC_RB_DIR 3
`define TFC_RB_D4Y 2
`define TFC_RB_FSE 1
`define TFC_RB_MOSC 0
// Transmit control A fields
`define TFC_TA_CLKF 7
`define TFC_TA_FPT 6
`define TFC_TA_CPT 5
`define TFC_TA_SSE 4
`define TFC_TA_GB7 3
`define TFC_TA_DLS 2
`define TFC_TA_BLUE 1
`define TFC_TA_YEL 0
// Out-of-frame windows and sync qualify counts
`define TFC_OOF_WIN_4 3'd4
`define TFC_OOF_WIN_5 3'd5
`define TFC_OOF_WIN_6 3'd6
`define TFC_OOF_ERRS 3'd2
`define TFC_QUAL_SHORT 5'd10
`define TFC_QUAL_LONG 5'd24
// Transmit clock loss: cycles of mclk with no edge
`define TFC_TRANSMIT_LINE_CLOCK_LOSS_NS 2000
`define TFC_CLK_NS 10
`define TFC_TRANSMIT_LINE_CLOCK_LOSS_CYC (`TFC_TRANSMIT_LINE_CLOCK_LOSS_NS / `TFC_CLK_NS)
`endif

// file: verif/tfc_ctrl_bank_monitor.sv
/*
 Port checker for the control register bank, bound to its top module.
 Assumes mclk_i at 100 MHz and a synchronous active-high rst_i.
*/
`timescale 1ns/1ps
module tfc_ctrl_bank_monitor (
	input wire mclk_i,
	input wire rst_i,
	input wire cs_n_i,
	input wire rd_n_i,
	input wire [7:0] rdata_o,
	input wire rx_frame_i,
	input wire tx_frame_i,
	input wire rx_excess_zeros_i,
	input wire rx_fbit_valid_i,
	input wire rx_fbit_err_i,
	input wire violation_count_excess_zero_o,
	input wire path_count_inc_o,
	input wire [4:0] rx_qualify_count_o,
	input wire receive_zero_byte_interchange_en_o,
	input wire receive_sync_multiframe_mode_o,
	input wire receive_sync_double_wide_o,
	input wire receive_sync_pin_oe_n_o,
	input wire receive_d4_yellow_select_o,
	input wire transmit_blue_alarm_o,
	input wire transmit_yellow_alarm_o,
	input wire global_bit7_stuffing_o,
	input wire tx_out_valid_o,
	input wire tx_out_ready_i
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	wire rd = !cs_n_i && !rd_n_i;
	property p_tx_hold;
		!tx_frame_i |=> $stable({transmit_blue_alarm_o, transmit_yellow_alarm_o,
			global_bit7_stuffing_o});
	endproperty
	a_tx_hold: assert property (p_tx_hold) else $error("tx control moved off frame");
	property p_rx_hold;
		!rx_frame_i && !$past(rx_frame_i) |=> $stable({rx_qualify_count_o,
			receive_zero_byte_interchange_en_o, receive_d4_yellow_select_o});
	endproperty
	a_rx_hold: assert property (p_rx_hold) else $error("rx control moved off frame");
	property p_sync_in;
		receive_sync_pin_oe_n_o |-> !receive_sync_double_wide_o && !receive_sync_multiframe_mode_o;
	endproperty
	a_sync_in: assert property (p_sync_in) else $error("sync modes on with pin input");
	property p_vcf;
		violation_count_excess_zero_o |-> $past(rx_excess_zeros_i);
	endproperty
	a_vcf: assert property (p_vcf) else $error("excess zero count without event");
	property p_path;
		path_count_inc_o |-> $past(rx_fbit_valid_i && rx_fbit_err_i);
	endproperty
	a_path: assert property (p_path) else $error("path count without framing error");
	property p_qual;
		rx_qualify_count_o == 5'd10 || rx_qualify_count_o == 5'd24;
	endproperty
	a_qual: assert property (p_qual) else $error("qualify count not 10 or 24");
	property p_rdata;
		!rd && !$past(rd) |=> $stable(rdata_o);
	endproperty
	a_rdata: assert property (p_rdata) else $error("read data moved without read");
	property p_buf_hold;
		tx_out_valid_o && !tx_out_ready_i |=> tx_out_valid_o;
	endproperty
	a_buf_hold: assert property (p_buf_hold) else $error("word dropped during stall");
endmodule // tfc_ctrl_bank_monitor

bind tfc_ctrl_bank tfc_ctrl_bank_monitor i_mon (.mclk_i, .rst_i, .cs_n_i, .rd_n_i, .rdata_o,
	.rx_frame_i, .tx_frame_i, .rx_excess_zeros_i, .rx_fbit_valid_i, .rx_fbit_err_i,
	.violation_count_excess_zero_o, .path_count_inc_o, .rx_qualify_count_o,
	.receive_zero_byte_interchange_en_o, .receive_sync_multiframe_mode_o,
	.receive_sync_double_wide_o, .receive_sync_pin_oe_n_o, .receive_d4_yellow_select_o,
	.transmit_blue_alarm_o, .transmit_yellow_alarm_o, .global_bit7_stuffing_o,
	.tx_out_valid_o, .tx_out_ready_i);

// file: verif/tfc_far_end.sv
/*
 Far-side model: word sink behind the transmit buffer, transmit line clock.
 Assumes the bench sets the stall and clock run levels.
*/
`timescale 1ns/1ps
module tfc_far_end (
	input wire mclk_i,
	input wire stall_i,
	input wire run_i,
	input wire valid_i,
	input wire [7:0] word_i,
	output wire ready_o,
	output reg line_clk_o = 1'b0,
	output reg [23:0] got_o = 24'h0
);
	assign ready_o = !stall_i;
	// Stands still while stopped, so the bank sees no edges
	always #324 if (run_i) line_clk_o = !line_clk_o;
	always @(posedge mclk_i) if (valid_i && ready_o) got_o <= {got_o[15:0], word_i};
endmodule // tfc_far_end

// file: verif/test_tfc_ctrl_bank.sv
/*
 Self-checking bench for the control register bank.
 Assumes the bank, checker and far-side model are compiled before it.
*/
`timescale 1ns/1ps
module test_tfc_ctrl_bank;
	logic mclk_i = '0, rst_i = 1'b1, cs_n_i = 1'b1, wr_n_i = 1'b1, rd_n_i = 1'b1;
	logic [7:0] addr_i = '0, wdata_i = '0, tx_word_i = '0;
	logic rx_frame_i = '0, tx_frame_i = '0, receive_elastic_store_en_i = '0, stall = '0;
	logic tx_d4_yellow_select_i = '0, receive_carrier_loss_i = '0, rx_fbit_valid_i = '0;
	logic rx_excess_zeros_i = '0, tx_word_valid_i = '0, run = 1'b1;
	logic fs = '0, ferr = 1'b1, esf = '0, oofi = '0, mos = '0;
	logic [2:0] rx_mf_index_i = '0;
	wire [7:0] rdata_o, rx_sub_code_o, tx_out_word_o;
	wire [4:0] rx_qualify_count_o;
	wire [23:0] got;
	wire vcz, pci, mfc, oof, crcv;
	wire tx_word_ready_o, rx_resync_o, rx_sync_cross_couple_o, tx_out_valid_o, tx_out_ready_i;
	wire transmit_line_clock_i, tx_use_recovered_clock_o, receive_zero_byte_interchange_en_o;
	wire receive_sync_double_wide_o, receive_sync_multiframe_mode_o, receive_sync_pin_oe_n_o;
	wire receive_d4_yellow_select_o, framing_bit_pass_through_o, crc_pass_through_o;
	wire software_signaling_insert_en_o, global_bit7_stuffing_o, data_link_source_select_o;
	wire transmit_blue_alarm_o, transmit_yellow_alarm_o, transmit_d4_yellow_select_o;
	wire [7:0] txv = {transmit_d4_yellow_select_o, framing_bit_pass_through_o,
		crc_pass_through_o, software_signaling_insert_en_o, global_bit7_stuffing_o,
		data_link_source_select_o, transmit_blue_alarm_o, transmit_yellow_alarm_o};
	wire [4:0] rxv = {receive_sync_pin_oe_n_o, receive_sync_multiframe_mode_o,
		receive_sync_double_wide_o, receive_zero_byte_interchange_en_o, receive_d4_yellow_select_o};
	logic [7:0] mw [8] = '{8'h1E, 8'h0B, 8'h0B, 8'h1E, 8'h9E, 8'h8B, 8'h8B, 8'h9E};
	logic [7:0] rbw [3] = '{8'h5C, 8'h50, 8'h20};
	logic [4:0] rbe [3] = '{5'h13, 5'h0A, 5'h04};
	int bad_count = 0, n_checks = 0, k;

	tfc_ctrl_bank i_dut (.mclk_i, .rst_i, .cs_n_i, .wr_n_i, .rd_n_i, .addr_i, .wdata_i,
		.rdata_o, .rx_frame_i, .tx_frame_i, .receive_elastic_store_en_i, .tx_d4_yellow_select_i,
		.out_of_frame_i(oofi), .receive_carrier_loss_i, .rx_fbit_valid_i, .rx_fbit_err_i(ferr),
		.rx_fbit_is_fs_i(fs), .rx_excess_zeros_i, .rx_mf_out_of_sync_i(mos), .rx_mf_index_i,
		.transmit_line_clock_i, .tx_word_valid_i, .tx_word_ready_o, .tx_word_i, .rx_resync_o,
		.rx_oof_o(oof), .rx_qualify_count_o, .rx_sync_cross_couple_o, .rx_sync_crc_verify_o(crcv),
		.rx_esf_mode_i(esf), .rx_sub_code_o, .receive_zero_byte_interchange_en_o,
		.receive_sync_double_wide_o, .receive_sync_multiframe_mode_o, .receive_sync_pin_oe_n_o,
		.receive_d4_yellow_select_o, .violation_count_excess_zero_o(vcz), .path_count_inc_o(pci),
		.mf_count_inc_o(mfc), .tx_use_recovered_clock_o, .framing_bit_pass_through_o,
		.crc_pass_through_o, .software_signaling_insert_en_o, .global_bit7_stuffing_o,
		.data_link_source_select_o, .transmit_blue_alarm_o, .transmit_yellow_alarm_o,
		.transmit_d4_yellow_select_o, .tx_out_valid_o, .tx_out_ready_i, .tx_out_word_o);
	tfc_far_end i_far (.mclk_i, .stall_i(stall), .run_i(run), .valid_i(tx_out_valid_o),
		.word_i(tx_out_word_o), .ready_o(tx_out_ready_i), .line_clk_o(transmit_line_clock_i),
		.got_o(got));

	task tick(int n = 1);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask
	task chk(string s, logic [23:0] e, logic [23:0] g);
		n_checks++;
		if (g !== e) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", s, e, g);
		end
	endtask
	task wr(logic [7:0] a, d);
		{cs_n_i, wr_n_i, addr_i, wdata_i} = {2'b00, a, d};
		tick();
		{cs_n_i, wr_n_i} = 2'b11;
		tick();
	endtask
	task rdc(logic [7:0] a, e);
		{cs_n_i, rd_n_i, addr_i} = {2'b00, a};
		tick();
		{cs_n_i, rd_n_i} = 2'b11;
		tick();
		chk("rdata", e, rdata_o);
	endtask
	task fr(bit tx);
		if (tx) tx_frame_i = 1'b1;
		else rx_frame_i = 1'b1;
		tick();
		{rx_frame_i, tx_frame_i} = 2'b00;
		tick();
	endtask
	// Valid stays up between words; caller lowers it
	task push(logic [7:0] w);
		{tx_word_valid_i, tx_word_i} = {1'b1, w};
		while (!tx_word_ready_o) tick();
		tick();
	endtask
	task rs(bit e);
		k = 0;
		repeat (10) begin
			k += rx_resync_o;
			tick();
		end
		chk("resync", e, k != 0);
	endtask

	task t_regs;
		chk("code", 8'h7F, rx_sub_code_o);
		chk("qual", 5'd10, rx_qualify_count_o);
		rdc(8'h2B, 8'h00);
		rdc(8'h35, 8'h00);
		wr(8'h2C, 8'hA5);
		wr(8'h36, 8'hFF);
		rdc(8'h2C, 8'hA5);
		rdc(8'h36, 8'h00);
	endtask
	task t_tx;
		tx_d4_yellow_select_i = 1'b1;
		wr(8'h35, 8'h55);
		chk("tx", 8'h00, txv);
		fr(1);
		chk("tx", 8'hD5, txv);
		run = 1'b0;
		tick(250);
		chk("fallback", 0, tx_use_recovered_clock_o);
		run = 1'b1;
		tx_d4_yellow_select_i = 1'b0;
		wr(8'h35, 8'hAA);
		fr(1);
		chk("tx", 8'h2A, txv);
		push(8'h5A);
		tx_word_valid_i = 1'b0;
		tick(4);
		chk("word", 8'hFF, got[7:0]);
		tick(40);
		run = 1'b0;
		tick(150);
		chk("fallback", 0, tx_use_recovered_clock_o);
		tick(100);
		chk("fallback", 1, tx_use_recovered_clock_o);
		run = 1'b1;
		wr(8'h35, 8'h55);
		fr(1);
	endtask
	task t_buf;
		stall = 1'b1;
		push(8'hA1);
		push(8'hA2);
		tx_word_i = 8'hA3;
		tick(4);
		chk("ready", 0, tx_word_ready_o);
		stall = 1'b0;
		push(8'hA3);
		tx_word_valid_i = 1'b0;
		tick(4);
		chk("words", 24'hA1_A2A3, got);
	endtask
	task t_rx;
		wr(8'h2B, 8'h8C);
		chk("qual", 5'd10, rx_qualify_count_o);
		fr(0);
		chk("qual", 5'd24, rx_qualify_count_o);
		chk("cross", 1, rx_sync_cross_couple_o);
		esf = 1'b1;
		tick();
		chk("crc", 1, crcv);
		chk("cross", 0, rx_sync_cross_couple_o);
		esf = 1'b0;
		{rx_excess_zeros_i, rx_fbit_valid_i} = 2'b11;
		tick();
		chk("vcz", 1, vcz);
		chk("pcv", 1, pci);
		chk("mfc", 0, mfc);
		{rx_excess_zeros_i, ferr} = 2'b00;
		tick();
		chk("vcz", 0, vcz);
		chk("pcv", 0, pci);
		{ferr, fs} = 2'b11;
		tick();
		chk("pcv", 0, pci);
		{rx_fbit_valid_i, fs} = 2'b00;
		chk("oof", 0, oof);
		tick(2);
		chk("oof", 1, oof);
		{rx_frame_i, mos} = 2'b11;
		tick();
		chk("mfc", 1, mfc);
		{rx_frame_i, mos} = 2'b00;
		receive_elastic_store_en_i = 1'b1;
		for (k = 0; k < 3; k++) begin
			wr(8'h2C, rbw[k]);
			fr(0);
			chk("rxmode", rbe[k], rxv);
		end
		wr(8'h2C, 8'h80);
		fr(0);
		for (k = 0; k < 8; k++) begin
			rx_mf_index_i = k[2:0];
			tick(2);
			chk("code", mw[k], rx_sub_code_o);
		end
	endtask
	task t_resync;
		wr(8'h2B, 8'h8D);
		rs(1);
		chk("oof", 0, oof);
		wr(8'h2B, 8'h8D);
		rs(0);
		receive_carrier_loss_i = 1'b1;
		rs(1);
		wr(8'h2B, 8'h4C);
		fr(0);
		rs(0);
		oofi = 1'b1;
		rs(1);
		wr(8'h2B, 8'h0E);
		fr(0);
		rs(0);
		{receive_carrier_loss_i, oofi} = 2'b00;
	endtask

	task give_verdict;
		if (bad_count == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial forever #5 mclk_i = !mclk_i;
	initial begin
		repeat (20000) @(posedge mclk_i);
		bad_count++;
		give_verdict();
	end
	initial begin
		repeat (20) @(posedge mclk_i);
		#1 rst_i = 1'b0;
		t_regs();
		t_tx();
		t_buf();
		t_rx();
		t_resync();
		give_verdict();
	end
endmodule // test_tfc_ctrl_bank
